// ### iev_core.sv
// Interrupt and exception vectoring unit
//
// Contract
// (RULE1) Non-maskable pin gives vector 2, never suppressed
// (RULE2) Maskable from request pin or serial pins
// (RULE3) Maskable requests wait while enable flag clear
// (RULE4) Software interrupt instruction always taken; core ignores swint unless idle with no exception and no unblocked NMI pending
// (RULE5) Vectors 0-31 for exceptions and non-maskable
// (RULE6) Vectors 32-255 legal for maskable sources
// (RULE7) Controller supplies vector during acknowledge cycle
// (RULE8) Divide error: vector 0, fault, no code
// (RULE9) Debug: vector 1, fault or trap, no code
// (RULE10) Breakpoint 3, overflow 4, traps, no code
// (RULE11) Bounds 5, invalid opcode 6, faults, no code
// (RULE12) No device 7, float error 16, faults
// (RULE13) Double fault: vector 8, abort, zero code
// (RULE14) Never vector 9, 15 or 19-31
// (RULE15) Invalid task state: vector 10, fault, code
// (RULE16) Segment absent: vector 11, fault, code
// (RULE17) Stack failure: vector 12, fault, code
// (RULE18) Protection 13 fault/trap, paging 14 fault, code
// (RULE19) Alignment 17 zero code; machine check 18 abort
// (RULE20) Suspend program, run handler, then resume
// (RULE21) Enable flag clear after reset
// (RULE22) Block non-maskable until interrupt return
// (RULE23) Vector carried as 8 bits, class, code flag
`timescale 1ns/1ps
`include "iev_regs.svh"

module iev_core #(
  parameter bit MC_PUSHES_ERR = 1'b0
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // Interrupt pins
  input  wire logic              nmi_pin,
  input  wire logic              maskable_request_pin,
  input  wire logic [1:0]        local_serial_request_pins,
  // Acknowledge cycle with the external controller
  output logic                   intack,
  input  wire logic              ack_valid,
  input  wire logic [7:0]        ack_vector,
  // Flag control from the instruction stream
  input  wire logic              flag_set,
  input  wire logic              flag_clear,
  input  wire logic              interrupt_return,
  // Software interrupts and exceptions
  input  wire iev_pkg::iev_swint_t swint,
  input  wire iev_pkg::iev_exc_t   exc,
  // Dispatch towards the handler entry logic
  output logic                   disp_valid,
  input  wire logic              disp_ready,
  output iev_pkg::iev_disp_t     disp,
  // Program state
  output logic                   suspend,
  output logic                   resume,
  output logic                   halted,
  output logic                   enable_flag,
  output logic                   nmi_blocked
);
  import iev_pkg::*;

  iev_state_t state;
  iev_state_t next_state;
  logic       nmi_prev;
  logic       nmi_pend;
  logic [7:0] ser_shift;
  logic [3:0] ser_cnt;
  logic [7:0] ser_vector;
  logic       ser_pend;
  logic       ser_done;
  logic       in_abort;
  logic       take_exc;
  logic       take_nmi;
  logic       take_sw;
  logic       take_pin;
  logic       take_ser;
  logic       entry_exc;
  iev_disp_t  exc_disp;
  iev_disp_t  next_disp;

  // Map a detected exception to its vector, class and error code
  function automatic iev_disp_t map_exc(input iev_exc_t e);
    iev_disp_t d;
    d.vector   = `IEV_VEC_BADOP;
    d.cls      = IEV_FAULT;
    d.push_err = 1'b0;
    d.err_zero = 1'b0;
    case (e.cause)
      IEV_C_DIVIDE: begin
        d.vector = `IEV_VEC_DIVIDE; // RULE8
      end
      IEV_C_DEBUG: begin
        d.vector = `IEV_VEC_DEBUG; // RULE9
        d.cls    = e.as_trap ? IEV_TRAP : IEV_FAULT; // RULE9
      end
      IEV_C_BREAK: begin
        d.vector = `IEV_VEC_BREAK; // RULE10
        d.cls    = IEV_TRAP;
      end
      IEV_C_OVERFLOW: begin
        d.vector = `IEV_VEC_OVERFLOW; // RULE10
        d.cls    = IEV_TRAP;
      end
      IEV_C_BOUNDS: begin
        d.vector = `IEV_VEC_BOUNDS; // RULE11
      end
      IEV_C_BADOP: begin
        d.vector = `IEV_VEC_BADOP; // RULE11
      end
      IEV_C_NODEV: begin
        d.vector = `IEV_VEC_NODEV; // RULE12
      end
      IEV_C_FLOAT: begin
        d.vector = `IEV_VEC_FLOAT; // RULE12
      end
      IEV_C_TASKSTATE: begin
        d.vector   = `IEV_VEC_TASKSTATE; // RULE15
        d.push_err = 1'b1;
      end
      IEV_C_ABSENT: begin
        d.vector   = `IEV_VEC_ABSENT; // RULE16
        d.push_err = 1'b1;
      end
      IEV_C_STACK: begin
        d.vector   = `IEV_VEC_STACK; // RULE17
        d.push_err = 1'b1;
      end
      IEV_C_PROTECT: begin
        d.vector   = `IEV_VEC_PROTECT; // RULE18
        d.cls      = e.as_trap ? IEV_TRAP : IEV_FAULT;
        d.push_err = 1'b1;
      end
      IEV_C_PAGING: begin
        d.vector   = `IEV_VEC_PAGING; // RULE18
        d.push_err = 1'b1;
      end
      IEV_C_ALIGN: begin
        d.vector   = `IEV_VEC_ALIGN; // RULE19
        d.push_err = 1'b1;
        d.err_zero = 1'b1;
      end
      IEV_C_MCHECK: begin
        d.vector   = `IEV_VEC_MCHECK; // RULE19
        d.cls      = IEV_ABORT;
        d.push_err = MC_PUSHES_ERR;
      end
      default: begin
        d.vector = `IEV_VEC_BADOP; // RULE14
      end
    endcase
    return d; // RULE5 RULE23
  endfunction : map_exc

  assign exc_disp = map_exc(exc);

  // Event selection at an instruction boundary, exceptions first
  always_comb begin
    take_exc = 1'b0;
    take_nmi = 1'b0;
    take_sw  = 1'b0;
    take_pin = 1'b0;
    take_ser = 1'b0;
    if (state == IEV_IDLE) begin
      if (exc.valid) begin
        take_exc = 1'b1;
      end else if (nmi_pend && !nmi_blocked) begin
        take_nmi = 1'b1; // RULE1 RULE22
      end else if (swint.valid) begin
        take_sw = 1'b1; // RULE4
      end else if (enable_flag && ser_pend) begin
        take_ser = 1'b1; // RULE2 RULE3
      end else if (enable_flag && maskable_request_pin) begin
        take_pin = 1'b1; // RULE2 RULE3
      end
    end
  end

  assign entry_exc = (state == IEV_ENTRY) && exc.valid;

  // Next dispatch contents
  always_comb begin
    next_disp = disp;
    if (take_exc) begin
      next_disp = exc_disp;
    end else if (take_nmi) begin
      next_disp = '{vector: `IEV_VEC_NMI, cls: IEV_MASKABLE_REQUEST_PIN, push_err: 1'b0, err_zero: 1'b0}; // RULE1
    end else if (take_sw) begin
      next_disp = '{vector: swint.vector, cls: IEV_TRAP, push_err: 1'b0, err_zero: 1'b0};
    end else if (take_ser) begin
      next_disp = '{vector: ser_vector, cls: IEV_MASKABLE_REQUEST_PIN, push_err: 1'b0, err_zero: 1'b0}; // RULE6
    end else if (state == IEV_ACK && ack_valid) begin
      next_disp = '{vector: ack_vector, cls: IEV_MASKABLE_REQUEST_PIN, push_err: 1'b0, err_zero: 1'b0}; // RULE6 RULE7
    end else if (entry_exc) begin
      next_disp = '{vector: `IEV_VEC_DOUBLE, cls: IEV_ABORT,
                    push_err: 1'b1, err_zero: 1'b1}; // RULE13
    end
  end

  // Sequencer
  always_comb begin
    next_state = state;
    case (state)
      IEV_IDLE: begin
        if (take_pin) begin
          next_state = IEV_ACK;
        end else if (take_exc || take_nmi || take_sw || take_ser) begin
          next_state = IEV_ENTRY;
        end
      end
      IEV_ACK: begin
        if (ack_valid) begin
          next_state = IEV_ENTRY; // RULE7
        end
      end
      IEV_ENTRY: begin
        if (entry_exc && disp.cls == IEV_ABORT && disp.vector == `IEV_VEC_DOUBLE) begin
          next_state = IEV_HALT;
        end else if (!entry_exc && disp_ready) begin
          next_state = IEV_HANDLE; // RULE20
        end
      end
      IEV_HANDLE: begin
        if (interrupt_return) begin
          next_state = in_abort ? IEV_HALT : IEV_IDLE; // RULE20
        end
      end
      IEV_HALT: begin
        next_state = IEV_HALT;
      end
      default: begin
        next_state = IEV_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= IEV_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Dispatch register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      disp <= '0;
    end else begin
      disp <= next_disp; // RULE23
    end
  end

  // Abort class handlers do not return to the program
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      in_abort <= 1'b0;
    end else if (state == IEV_ENTRY && next_state == IEV_HANDLE) begin
      in_abort <= (disp.cls == IEV_ABORT); // RULE20
    end
  end

  // Interrupt enable flag, cleared by reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      enable_flag <= `IEV_IF_RST; // RULE21
    end else if (flag_set) begin
      enable_flag <= 1'b1; // RULE3
    end else if (flag_clear) begin
      enable_flag <= 1'b0; // RULE3
    end
  end

  // Non-maskable edge capture; a new edge wins over the clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_prev <= 1'b0;
      nmi_pend <= 1'b0;
    end else begin
      nmi_prev <= nmi_pin;
      if (nmi_pin && !nmi_prev) begin
        nmi_pend <= 1'b1; // RULE1
      end else if (take_nmi) begin
        nmi_pend <= 1'b0;
      end
    end
  end

  // Further non-maskable deliveries held off until interrupt return
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_blocked <= 1'b0;
    end else if (take_nmi) begin
      nmi_blocked <= 1'b1; // RULE22
    end else if (interrupt_return) begin
      nmi_blocked <= 1'b0; // RULE22
    end
  end

  // Serial message: pin 0 strobes a bit on pin 1, eight bits MSB first
  assign ser_done = local_serial_request_pins[0] && (ser_cnt == `IEV_SER_BITS - 4'h1);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ser_shift <= '0;
      ser_cnt   <= `IEV_SER_CNT_RST;
    end else if (local_serial_request_pins[0]) begin
      ser_shift <= {ser_shift[6:0], local_serial_request_pins[1]}; // RULE2
      ser_cnt   <= ser_done ? `IEV_SER_CNT_RST : ser_cnt + 4'h1;
    end
  end

  // A message completing as the pending one is taken wins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ser_pend   <= 1'b0;
      ser_vector <= '0;
    end else if (ser_done) begin
      ser_pend   <= 1'b1; // RULE2
      ser_vector <= {ser_shift[6:0], local_serial_request_pins[1]};
    end else if (take_ser) begin
      ser_pend <= 1'b0;
    end
  end

  // Resume pulse after a recoverable handler returns
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      resume <= 1'b0;
    end else begin
      resume <= (state == IEV_HANDLE) && interrupt_return && !in_abort; // RULE20
    end
  end

  // Handshake and state outputs
  assign intack     = (state == IEV_ACK); // RULE7
  assign disp_valid = (state == IEV_ENTRY) && !entry_exc;
  assign suspend    = (state != IEV_IDLE); // RULE20
  assign halted     = (state == IEV_HALT);

endmodule : iev_core

// ### iev_regs.svh
// Vector numbers, serial frame length and reset values of the vectoring unit
`ifndef IEV_REGS_SVH
`define IEV_REGS_SVH

`define IEV_VEC_DIVIDE    8'h00
`define IEV_VEC_DEBUG     8'h01
`define IEV_VEC_NMI       8'h02
`define IEV_VEC_BREAK     8'h03
`define IEV_VEC_OVERFLOW  8'h04
`define IEV_VEC_BOUNDS    8'h05
`define IEV_VEC_BADOP     8'h06
`define IEV_VEC_NODEV     8'h07
`define IEV_VEC_DOUBLE    8'h08
`define IEV_VEC_TASKSTATE 8'h0a
`define IEV_VEC_ABSENT    8'h0b
`define IEV_VEC_STACK     8'h0c
`define IEV_VEC_PROTECT   8'h0d
`define IEV_VEC_PAGING    8'h0e
`define IEV_VEC_FLOAT     8'h10
`define IEV_VEC_ALIGN     8'h11
`define IEV_VEC_MCHECK    8'h12
`define IEV_VEC_MASK_LO 8'h20
`define IEV_SER_BITS    4'h8
`define IEV_SER_CNT_RST 4'h0
`define IEV_IF_RST      1'b0

`endif

// ### iev_pkg.sv
// Types shared by the vectoring unit and its users
package iev_pkg;

  typedef enum logic [1:0] {
    IEV_FAULT = 2'h0,
    IEV_TRAP  = 2'h1,
    IEV_ABORT = 2'h2,
    IEV_MASKABLE_REQUEST_PIN  = 2'h3
  } iev_class_t;

  typedef enum logic [3:0] {
    IEV_C_DIVIDE    = 4'h0,
    IEV_C_DEBUG     = 4'h1,
    IEV_C_BREAK     = 4'h2,
    IEV_C_OVERFLOW  = 4'h3,
    IEV_C_BOUNDS    = 4'h4,
    IEV_C_BADOP     = 4'h5,
    IEV_C_NODEV     = 4'h6,
    IEV_C_TASKSTATE = 4'h7,
    IEV_C_ABSENT    = 4'h8,
    IEV_C_STACK     = 4'h9,
    IEV_C_PROTECT   = 4'ha,
    IEV_C_PAGING    = 4'hb,
    IEV_C_FLOAT     = 4'hc,
    IEV_C_ALIGN     = 4'hd,
    IEV_C_MCHECK    = 4'he
  } iev_cause_t;

  typedef enum logic [4:0] {
    IEV_IDLE   = 5'b00001,
    IEV_ACK    = 5'b00010,
    IEV_ENTRY  = 5'b00100,
    IEV_HANDLE = 5'b01000,
    IEV_HALT   = 5'b10000
  } iev_state_t;

  // Exception report from the execution pipeline
  typedef struct packed {
    logic       valid;
    iev_cause_t cause;
    logic       as_trap;
  } iev_exc_t;

  // Software interrupt instruction with its vector operand
  typedef struct packed {
    logic       valid;
    logic [7:0] vector;
  } iev_swint_t;

  // Event handed to the dispatch logic
  typedef struct packed {
    logic [7:0] vector;
    iev_class_t cls;
    logic       push_err;
    logic       err_zero;
  } iev_disp_t;

endpackage : iev_pkg

// ### iev_core_properties.sv
// Concurrent checks on the ports of the vectoring unit
`timescale 1ns/1ps
module iev_core_properties (
  // Clock and reset
  input wire logic               mclk,
  input wire logic               rst_n,
  // Acknowledge cycle
  input wire logic               intack,
  input wire logic               ack_valid,
  input wire logic [7:0]         ack_vector,
  // Control
  input wire logic               interrupt_return,
  input wire iev_pkg::iev_exc_t  exc,
  // Dispatch and state
  input wire logic               disp_valid,
  input wire logic               disp_ready,
  input wire iev_pkg::iev_disp_t disp,
  input wire logic               suspend,
  input wire logic               resume,
  input wire logic               enable_flag,
  input wire logic               nmi_blocked
);
  import iev_pkg::*;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_rst;
    disable iff (1'b0) $rose(rst_n) |-> !enable_flag && !nmi_blocked;
  endproperty
  property p_mask;
    $rose(intack) |-> $past(enable_flag);
  endproperty
  property p_nmi;
    $rose(nmi_blocked) |-> disp_valid && disp.vector == 8'h02 && disp.cls == IEV_MASKABLE_REQUEST_PIN;
  endproperty
  property p_ack;
    intack && ack_valid |=> disp_valid && disp.vector == $past(ack_vector) && disp.cls == IEV_MASKABLE_REQUEST_PIN;
  endproperty
  property p_rsvd;
    disp_valid && disp.cls != IEV_MASKABLE_REQUEST_PIN |-> !(disp.vector inside {8'h09, 8'h0f, [8'h13:8'h1f]});
  endproperty
  property p_df;
    disp_valid && disp.vector == 8'h08 |-> disp.cls == IEV_ABORT && disp.push_err && disp.err_zero;
  endproperty
  property p_trap;
    disp_valid && disp.vector inside {8'h03, 8'h04} |-> disp.cls == IEV_TRAP && !disp.push_err;
  endproperty
  property p_code;
    disp_valid && disp.cls != IEV_MASKABLE_REQUEST_PIN && disp.vector inside {[8'h0a:8'h0e]} |-> disp.push_err;
  endproperty
  property p_hold;
    disp_valid && !disp_ready && !exc.valid |=> disp_valid && $stable(disp) && suspend;
  endproperty
  property p_resume;
    interrupt_return && suspend && !disp_valid && disp.cls != IEV_ABORT |=> resume && !suspend;
  endproperty

  a_rst:    assert property (p_rst)    else $error("flags not clear after reset");
  a_mask:   assert property (p_mask)   else $error("acknowledge while flag clear");
  a_nmi:    assert property (p_nmi)    else $error("non-maskable dispatch wrong");
  a_ack:    assert property (p_ack)    else $error("acknowledged vector lost");
  a_rsvd:   assert property (p_rsvd)   else $error("reserved vector raised");
  a_df:     assert property (p_df)     else $error("double fault attributes wrong");
  a_trap:   assert property (p_trap)   else $error("breakpoint or overflow not trap");
  a_code:   assert property (p_code)   else $error("error code flag missing");
  a_hold:   assert property (p_hold)   else $error("dispatch not held");
  a_resume: assert property (p_resume) else $error("no resume after return");

  c_ack: cover property (intack && ack_valid);
  c_nmi: cover property ($rose(nmi_blocked));
  c_df:  cover property (disp_valid && disp.vector == 8'h08);
endmodule : iev_core_properties

// ### iev_ctrl_model.sv
// External interrupt controller answering acknowledge cycles
`timescale 1ns/1ps
module iev_ctrl_model (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst_n,
  // Setup from the bench
  input wire logic [3:0] lat,
  input wire logic [7:0] vec,
  // Acknowledge cycle
  input wire logic       intack,
  output logic           ack_valid,
  output logic [7:0]     ack_vector
);
  logic [3:0] cnt;
  logic       done;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_valid  <= 1'b0;
      ack_vector <= 8'h00;
      cnt        <= 4'h0;
      done       <= 1'b0;
    end else if (intack && !done) begin
      if (cnt == lat) begin
        ack_valid  <= 1'b1;
        ack_vector <= vec | 8'h20;
        done       <= 1'b1;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end else begin
      ack_valid  <= 1'b0;
      ack_vector <= ~ack_vector;
      if (!intack) begin
        cnt  <= 4'h0;
        done <= 1'b0;
      end
    end
  end
endmodule : iev_ctrl_model

// ### iev_tb.sv
// Self-checking bench of the vectoring unit
`timescale 1ns/1ps
module testbench;
  import iev_pkg::*;
  logic mclk, rst_n, nmi_pin, maskable_request_pin, intack, ack_valid;
  logic flag_set, flag_clear, interrupt_return, disp_valid, disp_ready;
  logic suspend, resume, halted, enable_flag, nmi_blocked;
  logic [1:0] local_serial_request_pins;
  logic [7:0] ack_vector, vec;
  logic [3:0] lat;
  iev_swint_t swint;
  iev_exc_t   exc;
  iev_disp_t  disp;
  int         n_errors = 0;
  int         checks_done = 0;
  localparam logic [7:0] EV [15] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
    8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h10, 8'h11, 8'h12};

  iev_core uut (.mclk(mclk), .rst_n(rst_n), .nmi_pin(nmi_pin),
    .maskable_request_pin(maskable_request_pin),
    .local_serial_request_pins(local_serial_request_pins), .intack(intack),
    .ack_valid(ack_valid), .ack_vector(ack_vector), .flag_set(flag_set),
    .flag_clear(flag_clear), .interrupt_return(interrupt_return), .swint(swint),
    .exc(exc), .disp_valid(disp_valid), .disp_ready(disp_ready), .disp(disp),
    .suspend(suspend), .resume(resume), .halted(halted),
    .enable_flag(enable_flag), .nmi_blocked(nmi_blocked));
  iev_ctrl_model ctrl (.mclk(mclk), .rst_n(rst_n), .lat(lat), .vec(vec),
    .intack(intack), .ack_valid(ack_valid), .ack_vector(ack_vector));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  task automatic do_reset();
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
  endtask : do_reset

  // One-cycle pulse on the flag set (to_set high) or flag clear input
  task automatic pulse1(input logic to_set);
    @(posedge mclk);
    if (to_set) begin
      flag_set <= 1'b1;
    end else begin
      flag_clear <= 1'b1;
    end
    @(posedge mclk);
    flag_set   <= 1'b0;
    flag_clear <= 1'b0;
  endtask : pulse1

  task automatic send_exc(input logic [3:0] c, input logic t);
    @(posedge mclk);
    exc <= '{1'b1, iev_cause_t'(c), t};
    @(posedge mclk);
    exc <= '0;
  endtask : send_exc

  // Wait for a dispatch, accept it, return from the handler
  task automatic serve(input string what, input logic [11:0] e, input logic fatal);
    int n;
    n = 0;
    #1;
    while (disp_valid !== 1'b1 && n < 40) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("dispatch", 12'(disp_valid), 12'h001);
    chk(what, disp, e);
    chk("suspend", 12'(suspend), 12'h001);
    @(posedge mclk);
    disp_ready <= 1'b1;
    @(posedge mclk);
    disp_ready <= 1'b0;
    interrupt_return <= 1'b1;
    @(posedge mclk);
    interrupt_return <= 1'b0;
    #1;
    chk("resume halted", 12'({resume, halted}), 12'({~fatal, fatal}));
  endtask : serve

  task automatic t_exceptions();
    logic [3:0] c;
    logic [1:0] k;
    for (int i = 0; i < 28; i++) begin
      c = 4'(i >> 1);
      k = (c == 4'h2 || c == 4'h3 || (i[0] && (c == 4'h1 || c == 4'ha))) ? 2'h1 : 2'h0;
      send_exc(c, i[0]);
      serve("exc", {EV[c], k, c inside {[4'h7:4'hb], 4'hd}, c == 4'hd}, 1'b0);
    end
    send_exc(4'hf, 1'b0);
    serve("unknown", {8'h06, 2'h0, 2'b00}, 1'b0);
    $display("exceptions done");
  endtask : t_exceptions

  task automatic t_aborts();
    @(posedge mclk);
    exc <= '{1'b1, IEV_C_PAGING, 1'b0};
    @(posedge mclk);
    exc <= '{1'b1, IEV_C_STACK, 1'b0};
    @(posedge mclk);
    exc <= '0;
    serve("double", {8'h08, 2'h2, 1'b1, 1'b1}, 1'b1);
    do_reset();
    send_exc(4'he, 1'b0);
    serve("mcheck", {8'h12, 2'h2, 1'b0, 1'b0}, 1'b1);
    pulse1(1'b1);
    #1;
    chk("flag set", 12'(enable_flag), 12'h001);
    do_reset();
    #1;
    chk("reset flags", 12'({enable_flag, nmi_blocked, halted, suspend, intack}), 12'h0);
    $display("aborts done");
  endtask : t_aborts

  task automatic t_nmi();
    @(posedge mclk);
    nmi_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    nmi_pin <= 1'b0;
    #1;
    chk("blocked", 12'(nmi_blocked), 12'h001);
    @(posedge mclk);
    nmi_pin <= 1'b1;
    serve("nmi", {8'h02, 2'h3, 2'b00}, 1'b0);
    serve("nmi held", {8'h02, 2'h3, 2'b00}, 1'b0);
    @(posedge mclk);
    nmi_pin <= 1'b0;
    $display("nmi done");
  endtask : t_nmi

  task automatic t_swint();
    logic [7:0] sv [3] = '{8'h20, 8'hff, 8'h80};
    foreach (sv[i]) begin
      @(posedge mclk);
      swint <= '{1'b1, sv[i]};
      @(posedge mclk);
      swint <= '0;
      serve("swint", {sv[i], 2'h1, 2'b00}, 1'b0);
    end
    $display("swint done");
  endtask : t_swint

  task automatic t_pin();
    logic [7:0] pv [2] = '{8'h20, 8'hff};
    foreach (pv[i]) begin
      @(posedge mclk);
      vec <= pv[i];
      lat <= 4'(3 * i);
      maskable_request_pin <= 1'b1;
      repeat (8) @(posedge mclk);
      #1;
      chk("masked pin", 12'({intack, suspend}), 12'h0);
      pulse1(1'b1);
      @(posedge mclk);
      maskable_request_pin <= 1'b0;
      serve("pin", {pv[i], 2'h3, 2'b00}, 1'b0);
      pulse1(1'b0);
    end
    $display("pin done");
  endtask : t_pin

  task automatic t_serial();
    logic [7:0] v;
    v = 8'ha5;
    for (int i = 7; i >= 0; i--) begin
      @(posedge mclk);
      local_serial_request_pins <= {v[i], 1'b1};
      @(posedge mclk);
      local_serial_request_pins <= {~v[i], 1'b0};
    end
    repeat (4) @(posedge mclk);
    #1;
    chk("masked serial", 12'(suspend), 12'h0);
    pulse1(1'b1);
    serve("serial", {v, 2'h3, 2'b00}, 1'b0);
    pulse1(1'b0);
    $display("serial done");
  endtask : t_serial

  initial begin
    rst_n = 1'b0;
    {nmi_pin, maskable_request_pin, flag_set, flag_clear} = '0;
    {interrupt_return, disp_ready, local_serial_request_pins} = '0;
    swint = '0;
    exc = '0;
    vec = 8'h20;
    lat = 4'h0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_exceptions();
    t_nmi();
    t_swint();
    t_pin();
    t_serial();
    t_aborts();
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    complete_run();
  end
endmodule : testbench

bind iev_core iev_core_properties u_props (.mclk(mclk), .rst_n(rst_n), .intack(intack),
  .ack_valid(ack_valid), .ack_vector(ack_vector), .interrupt_return(interrupt_return),
  .exc(exc), .disp_valid(disp_valid), .disp_ready(disp_ready), .disp(disp),
  .suspend(suspend), .resume(resume), .enable_flag(enable_flag),
  .nmi_blocked(nmi_blocked));
